// ---- design/ssq_access_guard.sv ----
module ssq_access_guard
  import ssq_pkg::*;
(
  // protection level and parameter number
  input  wire logic [15:0] level,
  input  wire logic [6:0]  pnum,
  // permissions
  output logic             rd_ok,
  output logic             wr_ok
);

  logic in_basic;
  logic in_exp1;
  logic in_exp2;
  logic is_19;

  always_comb begin
    in_basic = pnum < PN_EXP1_FIRST;                               // R13
    in_exp1  = (pnum >= PN_EXP1_FIRST) && (pnum < PN_EXP2_FIRST);  // R13
    in_exp2  = (pnum >= PN_EXP2_FIRST) && (pnum <= PN_LAST);       // R13
    is_19    = pnum == PN_PROTECT;
    // unknown settings fall back to the factory behaviour
    rd_ok    = in_basic;                                           // R14
    wr_ok    = in_basic;                                           // R14
    unique case (level)
      PROT_ONLY19: begin                                           // R15
        rd_ok = is_19;
        wr_ok = is_19;
      end
      PROT_RD1: begin                                              // R15
        rd_ok = in_basic | in_exp1;
        wr_ok = in_basic;
      end
      PROT_RW1: begin                                              // R15
        rd_ok = in_basic | in_exp1;
        wr_ok = in_basic | in_exp1;
      end
      PROT_RWALL: begin                                            // R15
        rd_ok = in_basic | in_exp1 | in_exp2;
        wr_ok = in_basic | in_exp1 | in_exp2;
      end
      PROT_LK_RD1, PROT_LK_RW1: begin                              // R16
        rd_ok = in_basic | in_exp1;
        wr_ok = is_19;
      end
      PROT_LK_ALL: begin                                           // R16
        rd_ok = in_basic | in_exp1 | in_exp2;
        wr_ok = is_19;
      end
      default: begin
      end
    endcase
  end

endmodule // ssq_access_guard

// ---- design/ssq_pkg.sv ----
package ssq_pkg;

  // parameter store
  localparam int          NUM_PARAMS     = 85;
  localparam int          PARAM_W        = 16;
  localparam int          PNUM_W         = 7;
  localparam logic [6:0]  PN_MODE        = 7'h00;
  localparam logic [6:0]  PN_FUNC1       = 7'h01;
  localparam logic [6:0]  PN_SPEED1      = 7'h08;
  localparam logic [6:0]  PN_SPEED2      = 7'h09;
  localparam logic [6:0]  PN_SPEED3      = 7'h0a;
  localparam logic [6:0]  PN_ACCEL       = 7'h0b;
  localparam logic [6:0]  PN_DECEL       = 7'h0c;
  localparam logic [6:0]  PN_SCURVE      = 7'h0d;
  localparam logic [6:0]  PN_PROTECT     = 7'h13;
  localparam logic [6:0]  PN_EXP1_FIRST  = 7'h14;
  localparam logic [6:0]  PN_EXP2_FIRST  = 7'h32;
  localparam logic [6:0]  PN_LAST        = 7'h54;

  // reset values
  localparam logic [15:0] RV_MODE        = 16'h0002;
  localparam logic [15:0] RV_FUNC1       = 16'h0002;
  localparam logic [15:0] RV_SPEED1      = 16'h0064;
  localparam logic [15:0] RV_SPEED2      = 16'h01f4;
  localparam logic [15:0] RV_SPEED3      = 16'h03e8;
  localparam logic [15:0] RV_PROTECT     = 16'h0000;
  localparam logic [15:0] RV_OTHER       = 16'h0000;

  // field layouts
  localparam logic [3:0]  MODE_SPEED     = 4'h2;
  localparam int          FUNC1_BRAKE_BIT = 4;
  localparam int          CTRL_ALARM_RST_BIT = 0;
  localparam int          STATE_DIR_BIT  = 3;
  localparam int          STATE_HALT_BIT = 4;
  localparam int          STATE_SPEED_LSB = 15;

  // protection settings
  localparam logic [15:0] PROT_FACTORY   = 16'h0000;
  localparam logic [15:0] PROT_ONLY19    = 16'h000a;
  localparam logic [15:0] PROT_RD1       = 16'h000b;
  localparam logic [15:0] PROT_RW1       = 16'h000c;
  localparam logic [15:0] PROT_RWALL     = 16'h000e;
  localparam logic [15:0] PROT_LK_RD1    = 16'h100b;
  localparam logic [15:0] PROT_LK_RW1    = 16'h100c;
  localparam logic [15:0] PROT_LK_ALL    = 16'h100e;

  // apb map
  localparam int          ADDR_W         = 12;
  localparam logic [11:0] OFF_STATUS     = 12'h200;
  localparam logic [11:0] OFF_MASK       = 12'h204;
  localparam logic [11:0] OFF_STATE      = 12'h208;
  localparam logic [11:0] OFF_CTRL       = 12'h20c;

  // interrupt bits
  localparam int          IRQ_W          = 5;
  localparam int          IRQ_HALT       = 0;
  localparam int          IRQ_ALARM      = 1;
  localparam int          IRQ_LIMIT      = 2;
  localparam int          IRQ_REJECT     = 3;
  localparam int          IRQ_STANDSTILL = 4;

  // alarm codes
  localparam logic [7:0]  HALT_ALARM_CODE = 8'he6;
  localparam logic [7:0]  EXT_ALARM_CODE  = 8'h01;
  localparam logic [7:0]  NO_ALARM_CODE   = 8'h00;

  // timing
  localparam int          CLOCK_HZ       = 10_000_000;
  localparam int          TICK_US        = 1;
  localparam int          TICK_CYCLES    = CLOCK_HZ / 1_000_000 * TICK_US;
  localparam int          US_PER_MS      = 1000;
  localparam int          RATED_RPM      = 3000;

  typedef enum logic [2:0] {
    ST_COAST, ST_BRAKE, ST_LOCK, ST_RUN, ST_RAMP, ST_LIMIT
  } ssq_state_t;

  typedef struct packed {
    logic drive_engage;
    logic halt_input;
    logic forward_travel_limit;
    logic reverse_travel_limit;
    logic forward_run;
    logic reverse_run;
    logic speed_select_a;
    logic speed_select_b;
  } ssq_inputs_t;

  typedef struct packed {
    logic [15:0] accel_ms;
    logic [15:0] decel_ms;
    logic        sudden;
  } ssq_ramp_cfg_t;

endpackage

// ---- design/ssq_speed_ramp.sv ----
module ssq_speed_ramp
  import ssq_pkg::*;
#(
  parameter int RATED = RATED_RPM,
  parameter int TICKS = TICK_CYCLES
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // command
  input  wire logic signed [16:0]  target,
  input  wire ssq_ramp_cfg_t       cfg,
  // output speed
  output logic signed [16:0]       speed_q,
  output logic                     at_target
);

  logic [15:0] tick_cnt_q;
  logic        tick;
  logic [31:0] acc_q;
  logic [15:0] time_ms;
  logic [31:0] thr;
  logic        decel;
  logic        step;

  function automatic logic [16:0] mag(input logic signed [16:0] v);
    mag = v[16] ? 17'(-v) : 17'(v);
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 16'h0000;
    end else if (tick) begin
      tick_cnt_q <= 16'h0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end

  assign tick      = tick_cnt_q == 16'(TICKS - 1);
  assign at_target = speed_q == target;

  always_comb begin
    decel   = (mag(target) < mag(speed_q)) || ((target[16] != speed_q[16]) && (speed_q != 0));
    // a sudden stop is a ramp with zero time
    time_ms = cfg.sudden ? 16'h0000 : (decel ? cfg.decel_ms : cfg.accel_ms);  // R10
    thr     = 32'(time_ms) * 32'(US_PER_MS);
    step    = (thr != 32'h0) && (acc_q >= thr);
  end

  // one unit of speed per threshold crossing; time counts from zero to rated speed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= 32'h0;
    end else if (at_target || (thr == 32'h0)) begin
      acc_q <= 32'h0;
    end else begin
      acc_q <= acc_q + (tick ? 32'(RATED) : 32'h0) - (step ? thr : 32'h0);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      speed_q <= 17'sh0;
    end else if (at_target) begin
      speed_q <= speed_q;
    end else if (thr == 32'h0) begin
      speed_q <= target;                                           // R10
    end else if (step) begin
      speed_q <= (target > speed_q) ? speed_q + 17'sh1 : speed_q - 17'sh1;
    end
  end

endmodule // ssq_speed_ramp

// ---- design/ssq_top.sv ----
// Contract
// [R1] power first, then engage; engaged drive is ready and holds the motor locked
// [R2] two speed select inputs choose which internal speed setpoint applies
// [R3] forward run alone turns CCW, reverse run alone turns CW
// [R4] setpoints in parameters 8-10, ramp times in parameters 11-13; the ramp reads only 11 and 12, and 13 is never used
// [R5] engage off shuts the power stage and lets the motor coast
// [R6] any alarm shuts the power stage and applies the dynamic brake
// [R7] halt off shuts power stage, dynamic brake, raises the halt alarm code
// [R8] travel limit off stops suddenly with lock; opposite direction still allowed
// [R9] both run inputs on or both off ramp down with deceleration time
// [R10] a sudden stop is a deceleration with zero time
// [R11] control mode and function selection 1 apply after a power cycle
// [R12] protection level applies after a power cycle
// [R13] parameters split into basic 0-19, group one 20-49, group two 50-84
// [R14] factory protection allows basic group only
// [R15] protection codes 000A, 000B, 000C, 000E decode as given
// [R16] codes 100B/100C/100E read like 000x but write parameter 19 only
// [R17] alarm and halt braking outrank limit stops and ramped stops
// [R18] a blocked parameter write is refused and leaves the value unchanged
module ssq_top
  import ssq_pkg::*;
#(
  parameter int RATED = RATED_RPM
) (
  // clock and reset
  input  wire logic               CLOCK,
  input  wire logic               RST_N,
  // apb slave
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [11:0]        PADDR,
  input  wire logic [31:0]        PWDATA,
  output logic      [31:0]        PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  // supply and alarm
  input  wire logic               POWER_GOOD,
  input  wire logic               ALARM_IN,
  // host discrete inputs
  input  wire logic               DRIVE_ENGAGE,
  input  wire logic               HALT_INPUT,
  input  wire logic               FORWARD_TRAVEL_LIMIT,
  input  wire logic               REVERSE_TRAVEL_LIMIT,
  input  wire logic               FORWARD_RUN,
  input  wire logic               REVERSE_RUN,
  input  wire logic               SPEED_SELECT_A,
  input  wire logic               SPEED_SELECT_B,
  // power stage and motion
  output logic                    BASE_ENABLE,
  output logic                    DYN_BRAKE,
  output logic                    SERVO_LOCK,
  output logic signed [16:0]      SPEED_CMD,
  output logic                    DIR_CCW,
  output logic                    BRAKE_INTERLOCK_OUT,
  output logic      [7:0]         HALT_ALARM_CODE_OUT,
  output logic      [2:0]         RUN_STATE,
  // interrupt
  output logic                    IRQ
);

  logic [15:0]        param_q [NUM_PARAMS];
  logic [15:0]        act_mode_q;
  logic [15:0]        act_func1_q;
  logic [15:0]        act_prot_q;
  logic               pg_q;
  logic               power_rise;

  ssq_inputs_t        din;
  logic               engage_ok;
  logic               speed_mode;
  logic               halt_alarm_q;
  logic               ext_alarm_q;
  logic               alarm_any;
  logic               run_active;
  logic [15:0]        setpoint;
  logic               fwd_only;
  logic               rev_only;
  logic               limit_stop;
  logic signed [16:0] target;
  ssq_ramp_cfg_t      ramp_cfg;
  logic signed [16:0] speed;
  logic               at_target;
  ssq_state_t         state_d;
  ssq_state_t         state_q;

  logic               apb_setup;
  logic               apb_access;
  logic [6:0]         pnum;
  logic               is_param;
  logic               rd_ok;
  logic               wr_ok;
  logic [31:0]        rdata_q;
  logic               err_q;
  logic               status_rd_q;
  logic [IRQ_W-1:0]   status_q;
  logic [IRQ_W-1:0]   mask_q;
  logic [IRQ_W-1:0]   events;
  logic               alarm_reset;
  logic               reject;

  function automatic logic [15:0] param_default(input logic [6:0] n);
    unique case (n)
      PN_MODE:    param_default = RV_MODE;
      PN_FUNC1:   param_default = RV_FUNC1;
      PN_SPEED1:  param_default = RV_SPEED1;
      PN_SPEED2:  param_default = RV_SPEED2;
      PN_SPEED3:  param_default = RV_SPEED3;
      PN_PROTECT: param_default = RV_PROTECT;
      default:    param_default = RV_OTHER;
    endcase
  endfunction

  function automatic logic param_hit(input logic [11:0] a);
    param_hit = (a[11:9] == 3'h0) && (a[1:0] == 2'h0) && (a[8:2] <= PN_LAST);
  endfunction

  // ---------------- apb decode
  assign apb_setup  = PSEL && !PENABLE;
  assign apb_access = PSEL && PENABLE;
  assign pnum       = PADDR[8:2];
  assign is_param   = param_hit(PADDR);
  assign PREADY     = 1'b1;
  assign PRDATA     = rdata_q;
  assign PSLVERR    = apb_access && err_q;
  assign alarm_reset = apb_access && PWRITE && !err_q && (PADDR == OFF_CTRL)
                       && PWDATA[CTRL_ALARM_RST_BIT];

  // access rights follow the level latched at the last power-up
  ssq_access_guard u_guard (
    .level (act_prot_q),
    .pnum  (pnum),
    .rd_ok (rd_ok),
    .wr_ok (wr_ok)
  );

  // read data and error are prepared in the setup cycle so both come from flops
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q     <= 32'h0;
      err_q       <= 1'b0;
      status_rd_q <= 1'b0;
    end else if (apb_setup) begin
      rdata_q     <= 32'h0;
      status_rd_q <= 1'b0;
      if (is_param) begin
        err_q <= PWRITE ? !wr_ok : !rd_ok;                         // R18
        if (!PWRITE && rd_ok) begin
          rdata_q <= {16'h0000, param_q[pnum]};
        end
      end else begin
        err_q <= !((PADDR == OFF_STATUS) || (PADDR == OFF_MASK)
                   || (PADDR == OFF_STATE) || (PADDR == OFF_CTRL));
        if (!PWRITE) begin
          unique case (PADDR)
            OFF_STATUS: begin
              rdata_q     <= 32'(status_q);
              status_rd_q <= 1'b1;
            end
            OFF_MASK:  rdata_q <= 32'(mask_q);
            OFF_STATE: rdata_q <= {speed, 10'h000, halt_alarm_q, DIR_CCW, state_q};
            default:   rdata_q <= 32'h0;
          endcase
        end
      end
    end
  end

  assign reject = apb_access && is_param && err_q;

  // ---------------- parameter store
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < NUM_PARAMS; i++) begin
        param_q[i] <= param_default(7'(i));
      end
    end else if (apb_access && PWRITE && is_param && !err_q) begin  // R18
      param_q[pnum] <= PWDATA[15:0];                               // R4
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      mask_q <= '0;
    end else if (apb_access && PWRITE && (PADDR == OFF_MASK)) begin
      mask_q <= PWDATA[IRQ_W-1:0];
    end
  end

  // ---------------- power-cycle latched settings
  // writes land in the store at once but steer nothing until power returns
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pg_q <= 1'b0;
    end else begin
      pg_q <= POWER_GOOD;
    end
  end

  assign power_rise = POWER_GOOD && !pg_q;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      act_mode_q  <= RV_MODE;
      act_func1_q <= RV_FUNC1;
      act_prot_q  <= RV_PROTECT;
    end else if (power_rise) begin
      act_mode_q  <= param_q[PN_MODE];                             // R11
      act_func1_q <= param_q[PN_FUNC1];                            // R11
      act_prot_q  <= param_q[PN_PROTECT];                          // R12
    end
  end

  // ---------------- alarms
  assign din = '{drive_engage:         DRIVE_ENGAGE,
                 halt_input:           HALT_INPUT,
                 forward_travel_limit: FORWARD_TRAVEL_LIMIT,
                 reverse_travel_limit: REVERSE_TRAVEL_LIMIT,
                 forward_run:          FORWARD_RUN,
                 reverse_run:          REVERSE_RUN,
                 speed_select_a:       SPEED_SELECT_A,
                 speed_select_b:       SPEED_SELECT_B};

  // the halt alarm stays latched until halt is back on and software resets it
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      halt_alarm_q <= 1'b0;
    end else if (!din.halt_input) begin
      halt_alarm_q <= 1'b1;                                        // R7
    end else if (alarm_reset) begin
      halt_alarm_q <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ext_alarm_q <= 1'b0;
    end else begin
      ext_alarm_q <= ALARM_IN;
    end
  end

  assign alarm_any  = halt_alarm_q || ALARM_IN;
  assign engage_ok  = POWER_GOOD && din.drive_engage;              // R1
  assign speed_mode = act_mode_q[3:0] == MODE_SPEED;
  assign run_active = engage_ok && !alarm_any && speed_mode;

  // ---------------- speed command
  always_comb begin
    unique case ({din.speed_select_b, din.speed_select_a})         // R2
      2'b01:   setpoint = param_q[PN_SPEED1];                      // R4
      2'b10:   setpoint = param_q[PN_SPEED2];                      // R4
      2'b11:   setpoint = param_q[PN_SPEED3];                      // R4
      default: setpoint = 16'h0000;
    endcase
  end

  assign fwd_only = din.forward_run && !din.reverse_run;
  assign rev_only = din.reverse_run && !din.forward_run;

  // a limit stops motion into it only; the opposite way stays open
  assign limit_stop = (fwd_only && !din.forward_travel_limit)      // R8
                   || (rev_only && !din.reverse_travel_limit)
                   || ((speed > 17'sh0) && !din.forward_travel_limit)
                   || ((speed < 17'sh0) && !din.reverse_travel_limit);

  always_comb begin
    ramp_cfg.accel_ms = param_q[PN_ACCEL];                         // R4
    ramp_cfg.decel_ms = param_q[PN_DECEL];                         // R4
    ramp_cfg.sudden   = 1'b0;
    target            = 17'sh0;
    if (!run_active) begin
      ramp_cfg.sudden = 1'b1;                                      // R6
    end else if (limit_stop) begin
      ramp_cfg.sudden = 1'b1;                                      // R8
    end else if (fwd_only) begin
      target = $signed({1'b0, setpoint});                          // R3
    end else if (rev_only) begin
      target = -$signed({1'b0, setpoint});                         // R3
    end
    // both on or both off leaves target zero on the decel ramp     R9
  end

  ssq_speed_ramp #(
    .RATED (RATED),
    .TICKS (TICK_CYCLES)
  ) u_ramp (
    .clk       (CLOCK),
    .rst_n     (RST_N),
    .target    (target),
    .cfg       (ramp_cfg),
    .speed_q   (speed),
    .at_target (at_target)
  );

  // ---------------- stop pattern selection
  always_comb begin
    if (alarm_any) begin
      state_d = ST_BRAKE;                                          // R17
    end else if (!engage_ok) begin
      state_d = ST_COAST;                                          // R5
    end else if (limit_stop && (target == 17'sh0)) begin
      state_d = ST_LIMIT;                                          // R8
    end else if (at_target && (target == 17'sh0)) begin
      state_d = ST_LOCK;                                           // R1
    end else if (target == 17'sh0) begin
      state_d = ST_RAMP;                                           // R9
    end else begin
      state_d = ST_RUN;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_COAST;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      BASE_ENABLE         <= 1'b0;
      DYN_BRAKE           <= 1'b0;
      SERVO_LOCK          <= 1'b0;
      DIR_CCW             <= 1'b0;
      BRAKE_INTERLOCK_OUT <= 1'b0;
      HALT_ALARM_CODE_OUT <= NO_ALARM_CODE;
    end else begin
      BASE_ENABLE         <= run_active;                           // R5
      DYN_BRAKE           <= alarm_any;                            // R6
      SERVO_LOCK          <= (state_d == ST_LOCK) || (state_d == ST_LIMIT);  // R1
      DIR_CCW             <= target > 17'sh0;                      // R3
      BRAKE_INTERLOCK_OUT <= act_func1_q[FUNC1_BRAKE_BIT] && run_active;
      HALT_ALARM_CODE_OUT <= halt_alarm_q ? HALT_ALARM_CODE :      // R7
                             (ALARM_IN ? EXT_ALARM_CODE : NO_ALARM_CODE);
    end
  end

  assign SPEED_CMD = speed;
  assign RUN_STATE = state_q;

  // ---------------- interrupts
  always_comb begin
    events                 = '0;
    events[IRQ_HALT]       = !din.halt_input && !halt_alarm_q;
    events[IRQ_ALARM]      = ALARM_IN && !ext_alarm_q;
    events[IRQ_LIMIT]      = (state_d == ST_LIMIT) && (state_q != ST_LIMIT);
    events[IRQ_REJECT]     = reject;
    events[IRQ_STANDSTILL] = (state_d == ST_LOCK) && (state_q != ST_LOCK);
  end

  // only bits that were returned are cleared, and a new event wins
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      status_q <= '0;
    end else if (apb_access && !PWRITE && status_rd_q) begin
      status_q <= (status_q & ~rdata_q[IRQ_W-1:0]) | events;
    end else begin
      status_q <= status_q | events;
    end
  end

  assign IRQ = |(status_q & mask_q);

endmodule // ssq_top

// ---- tb/servo_speed_mode_sequencer_test.sv ----
module servo_speed_mode_sequencer_test
  import ssq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, pg = 1, alarm = 0, ok;
  logic        pready, perr, irq;
  logic [2:0]  rs;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [15:0] p20 = '0, v, c;
  logic [32:0] e, q[$];
  int          errors = 0, n_tests = 0, sp;
  ssq_inputs_t want = 8'h70, pins;
  logic [15:0] codes[8] = '{16'h000a, 16'h000b, 16'h000c, 16'h000e,
                            16'h100b, 16'h100c, 16'h100e, 16'h0000};
  always #50 clk = ~clk;
  ssq_host u_host (.clk(clk), .power_good(pg), .want(want), .pins(pins));
  ssq_top DUT (.CLOCK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(perr),
    .POWER_GOOD(pg), .ALARM_IN(alarm), .DRIVE_ENGAGE(pins.drive_engage),
    .HALT_INPUT(pins.halt_input), .FORWARD_TRAVEL_LIMIT(pins.forward_travel_limit),
    .REVERSE_TRAVEL_LIMIT(pins.reverse_travel_limit), .FORWARD_RUN(pins.forward_run),
    .REVERSE_RUN(pins.reverse_run), .SPEED_SELECT_A(pins.speed_select_a),
    .SPEED_SELECT_B(pins.speed_select_b), .BASE_ENABLE(), .DYN_BRAKE(), .SERVO_LOCK(),
    .SPEED_CMD(), .DIR_CCW(), .BRAKE_INTERLOCK_OUT(), .HALT_ALARM_CODE_OUT(),
    .RUN_STATE(rs), .IRQ(irq));
  task automatic chk(input string n, input logic [32:0] x, input logic [32:0] g);
    n_tests++;
    if (g !== x) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic results;
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // expected {slverr, rdata}; writes only judge slverr
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] x);
    @(posedge clk);
    q.push_back(x);
    {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    {psel, pen} <= 2'b00;
  endtask
  always @(posedge clk) begin
    if (psel && pen && pready) begin
      e = q.pop_front();
      chk(pwr ? "wr" : "rd", e, {perr, pwr ? e[31:0] : prdata});
    end
  end
  function automatic logic [32:0] ex(input logic k, input logic [15:0] d);
    return k ? {17'h0, d} : {1'b1, 32'h0};
  endfunction
  task automatic go(input ssq_inputs_t w, input int n);
    want <= w;
    repeat (n) @(posedge clk);
  endtask
  task automatic st(input logic [31:0] d);
    apb(0, OFF_STATE, '0, {1'b0, d});
  endtask
  initial begin
    #3000000;
    errors++;
    results();
  end
  initial begin
    sp = $urandom(32'hf3d4);
    // floor keeps the ramp long enough to be caught mid-way
    sp = $urandom_range(200, 60);
    repeat (5) @(posedge clk);
    rst_n <= 1;
    apb(1, 12'h020, 32'(sp), '0);
    apb(0, 12'h020, '0, 33'(sp));
    apb(0, 12'h02c, '0, '0);
    apb(1, OFF_MASK, 32'h1, '0);
    apb(1, 12'h000, '0, '0);
    go(8'hf0, 4);
    st(32'h2);
    go(8'hfa, 4);
    st({17'(sp), 15'h000b});
    go(8'hda, 4);
    st(32'h5);
    go(8'hd6, 4);
    st({-17'(sp), 15'h0003});
    alarm <= 1;
    go(8'hd6, 4);
    st(32'h1);
    go(8'hf0, 2);
    alarm <= 0;
    go(8'hf0, 6);
    st(32'h2);
    apb(1, 12'h030, 32'h1, '0);
    go(8'hfa, 6);
    go(8'hfe, 8);
    chk("ramp", 33'h4, {30'h0, rs});
    go(8'hfe, 3000);
    st(32'h2);
    go(8'hb0, 6);
    st(32'h11);
    chk("irq", 33'h1, {32'h0, irq});
    apb(0, OFF_STATUS, '0, 33'h17);
    @(posedge clk);
    chk("irq", 33'h0, {32'h0, irq});
    apb(1, OFF_MASK, '0, '0);
    go(8'hf0, 2);
    apb(1, OFF_CTRL, 32'h1, '0);
    go(8'h70, 4);
    st(32'h0);
    apb(0, 12'h300, '0, {1'b1, 32'h0});
    apb(1, 12'h04c, 32'h000e, '0);
    apb(0, 12'h0c8, '0, {1'b1, 32'h0});
    foreach (codes[i]) begin
      c = codes[i];
      v = 16'($urandom());
      apb(1, 12'h04c, {16'h0, c}, '0);
      pg <= 0;
      repeat (3) @(posedge clk);
      pg <= 1;
      @(posedge clk);
      apb(0, 12'h020, '0, ex(c != 16'h000a, 16'(sp)));
      apb(0, 12'h050, '0, ex(c[3:0] >= 4'hb, p20));
      apb(0, 12'h0c8, '0, ex(c[3:0] == 4'he, '0));
      ok = !c[12] && c[3:0] >= 4'hc;
      apb(1, 12'h050, {16'h0, v}, {!ok, 32'h0});
      if (ok) p20 = v;
    end
    results();
  end
endmodule // servo_speed_mode_sequencer_test

// ---- tb/ssq_asserts.sv ----
module ssq_asserts
  import ssq_pkg::*;
(
  // clock and reset
  input wire logic               CLOCK,
  input wire logic               RST_N,
  // host side
  input wire logic               ALARM_IN,
  input wire logic               DRIVE_ENGAGE,
  input wire logic               HALT_INPUT,
  input wire logic               FORWARD_TRAVEL_LIMIT,
  input wire logic               FORWARD_RUN,
  input wire logic               REVERSE_RUN,
  // motion outputs
  input wire logic               BASE_ENABLE,
  input wire logic               DYN_BRAKE,
  input wire logic               SERVO_LOCK,
  input wire logic signed [16:0] SPEED_CMD,
  input wire logic               DIR_CCW,
  input wire logic [7:0]         HALT_ALARM_CODE_OUT,
  input wire logic [2:0]         RUN_STATE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  property p_lock; $rose(BASE_ENABLE) |-> SERVO_LOCK && RUN_STATE == 3'd2; endproperty
  a_lock: assert property (p_lock) else $error("engage without lock");
  property p_dir; REVERSE_RUN && !FORWARD_RUN |=> !DIR_CCW; endproperty
  a_dir: assert property (p_dir) else $error("reverse run turns ccw");
  property p_coast; !DRIVE_ENGAGE |=> !BASE_ENABLE && RUN_STATE != 3'd3; endproperty
  a_coast: assert property (p_coast) else $error("power stage on while disengaged");
  property p_alarm; ALARM_IN |=> DYN_BRAKE && !BASE_ENABLE; endproperty
  a_alarm: assert property (p_alarm) else $error("alarm without brake");
  // the halt alarm is latched first, so the brake shows one edge later than for an alarm
  property p_halt; $fell(HALT_INPUT) |-> ##2 DYN_BRAKE && HALT_ALARM_CODE_OUT == HALT_ALARM_CODE;
  endproperty
  a_halt: assert property (p_halt) else $error("halt without brake or code");
  property p_limit; !FORWARD_TRAVEL_LIMIT [*2] |=> SPEED_CMD <= 0; endproperty
  a_limit: assert property (p_limit) else $error("forward motion past limit");
  property p_sudden; ALARM_IN [*2] |=> SPEED_CMD == 0; endproperty
  a_sudden: assert property (p_sudden) else $error("sudden stop not immediate");
  property p_prio; ALARM_IN && !FORWARD_TRAVEL_LIMIT |=> RUN_STATE == 3'd1; endproperty
  a_prio: assert property (p_prio) else $error("limit outranked alarm");
  c_run: cover property (RUN_STATE == 3'd3 && DIR_CCW);
  c_limit: cover property (RUN_STATE == 3'd5);
  c_halt: cover property (DYN_BRAKE && HALT_ALARM_CODE_OUT == HALT_ALARM_CODE);
endmodule // ssq_asserts

bind ssq_top ssq_asserts u_chk (.*);

// ---- tb/ssq_host.sv ----
module ssq_host
  import ssq_pkg::*;
(
  // clock and supply
  input wire logic        clk,
  input wire logic        power_good,
  // requested levels and driven pins
  input wire ssq_inputs_t want,
  output ssq_inputs_t     pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // halt and limits start on so power-up has no stop pending
  initial pins = 8'h70;
  // engage is never raised ahead of supply
  always @(posedge clk) pins <= want & {power_good, 7'h7f};
endmodule // ssq_host
